// [core/lpw_sequencer.sv]
// Low power mode wake-source acceptance, pin qualification and warm-up sequencer
`timescale 1ns/1ps
`default_nettype none
module lpw_sequencer
   import lpw_pkg::*;
(
   input  wire logic                  clk_sys,          // 25 MHz clock
   input  wire logic                  nrst,             // Reset pin, active low
   input  wire logic                  enterReq,         // Pulse: enter requested mode
   input  wire logic [1:0]            modeSel,          // Requested low power mode
   input  wire logic [WARMUP_W-1:0]   warmup_duration,  // Warm-up length in cycles
   input  wire logic [NUM_EXT-1:0]    external_wake_irq,// External interrupt pins
   input  wire logic [NUM_EXT-1:0]    wakeDetectEn,     // Wake detection config bits
   input  wire logic [NUM_EXT-1:0]    cpuIrqEn,         // Processor acceptance of pins
   input  wire logic [NUM_PERIPH-1:0] periphIrq,        // Peripheral requests, same clock
   input  wire logic                  tickIrq,          // System tick request
   input  wire logic                  watchdog_nmi_request, // Watchdog NMI request
   input  wire logic                  nmiPinN,          // NMI pin, active low
   output logic [2:0]                 lowPowerState,    // Doze, light, deep
   output logic                       sysClkEn,         // System clock enable
   output logic                       oscStart,         // Internal oscillator running
   output logic                       irqHandleStart,   // Pulse: begin wake handling
   output logic                       resetBranch,      // Pulse: take reset handler
   output logic                       cutDomainReinit,  // Pulse: reinit power-cut domain
   output logic                       clkCfgReset       // Pulse: reset clock selects
);
   typedef struct packed {
      lpw_state_type        state;
      logic [1:0]           fromMode;
      logic                 nmiSrc;
      logic [CNT_W-1:0]     since;
      logic [CNT_W-1:0]     width;
      logic [CNT_W-1:0]     need;
      logic                 startPulse;
      logic                 sysClkEn;
      logic                 oscStart;
      logic                 irqHandle;
      logic                 resetBranch;
      logic                 cutReinit;
      logic                 cfgReset;
      logic [2:0]           lpState;
   } lpw_seq_type;

   logic [1:0]         rstSync;
   logic               rstN;
   logic [NUM_EXT-1:0] ext1, ext2, ext3;
   logic               nmi1, nmi2, nmi3;
   logic               tick1, tick2, tick3;
   logic               wdt1, wdt2, wdt3;
   logic [NUM_EXT-1:0] extQ;
   logic               nmiQ;
   logic               warmDone;
   lpw_seq_type        r;
   lpw_seq_type        next_r;

   // Stable value: only adopt a change once stage 2 and 3 agree
   function automatic logic settle(input logic s2, input logic s3, input logic prev);
      settle = (s2 == s3) ? s3 : prev;
   endfunction

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         ext1  <= '0;
         ext2  <= '0;
         ext3  <= '0;
         extQ  <= '0;
         nmi1  <= 1'b1;
         nmi2  <= 1'b1;
         nmi3  <= 1'b1;
         nmiQ  <= 1'b1;
         tick1 <= 1'b0;
         tick2 <= 1'b0;
         tick3 <= 1'b0;
         wdt1  <= 1'b0;
         wdt2  <= 1'b0;
         wdt3  <= 1'b0;
      end else begin
         ext1  <= external_wake_irq;
         ext2  <= ext1;
         ext3  <= ext2;
         for (int i = 0; i < NUM_EXT; i++) begin
            extQ[i] <= settle(ext2[i], ext3[i], extQ[i]);
         end
         nmi1  <= nmiPinN;
         nmi2  <= nmi1;
         nmi3  <= nmi2;
         nmiQ  <= settle(nmi2, nmi3, nmiQ);
         tick1 <= tickIrq;
         tick2 <= tick1;
         tick3 <= tick2;
         wdt1  <= watchdog_nmi_request;
         wdt2  <= wdt1;
         wdt3  <= wdt2;
      end
   end

   logic               tickQ;
   logic               wdtQ;
   assign tickQ = tick2 & tick3;
   assign wdtQ  = wdt2 & wdt3;

   lpw_warmup_counter u_warmup (
      .clk      (clk_sys),
      .rstN     (rstN),
      .start    (r.startPulse),
      .duration (warmup_duration),
      .done     (warmDone)
   );

   always_comb begin
      next_r = r;
      next_r.startPulse  = 1'b0;
      next_r.irqHandle   = 1'b0;
      next_r.resetBranch = 1'b0;
      next_r.cutReinit   = 1'b0;
      next_r.cfgReset    = 1'b0;
      if (r.since != '1) begin
         next_r.since = r.since + 16'h0001;
      end
      case (r.state)
         ST_RUN: begin
            next_r.sysClkEn = 1'b1;
            next_r.oscStart = 1'b1;
            next_r.lpState  = 3'b000;
            if (enterReq && modeSel != MODE_RUN) begin
               next_r.fromMode = modeSel;
               next_r.since    = '0;
               case (modeSel)
                  MODE_DOZE: begin
                     next_r.state   = ST_DOZE;
                     next_r.lpState = 3'b001;
                  end
                  MODE_LIGHT: begin
                     next_r.state    = ST_LIGHT;
                     next_r.lpState  = 3'b010;
                     next_r.sysClkEn = 1'b0;
                     next_r.oscStart = 1'b0;
                  end
                  default: begin
                     next_r.state    = ST_DEEP;
                     next_r.lpState  = 3'b100;
                     next_r.sysClkEn = 1'b0;
                     next_r.oscStart = 1'b0;
                  end
               endcase
            end
         end
         ST_DOZE: begin
            // Doze keeps the clock: any enabled source returns at once
            if (|periphIrq || tickQ || wdtQ || !nmiQ || |(extQ & cpuIrqEn)) begin
               next_r.state     = ST_RUN;
               next_r.irqHandle = 1'b1;
               next_r.lpState   = 3'b000;
            end
         end
         ST_LIGHT: begin
            // Peripheral, tick and watchdog requests are deliberately not looked at
            if (!nmiQ || |(extQ & cpuIrqEn & wakeDetectEn)) begin
               next_r.state      = ST_WARMUP;
               next_r.oscStart   = 1'b1;
               next_r.startPulse = 1'b1;
            end
         end
         ST_DEEP: begin
            next_r.width = '0;
            // Pulse length required depends on how long the part sat in deep stop
            next_r.need  = (r.since > 16'(SETTLE_CYC)) ? 16'(PULSE_SHORT_CYC)
                                                       : 16'(PULSE_LONG_CYC);
            if (!nmiQ) begin
               next_r.state  = ST_QUAL;
               next_r.nmiSrc = 1'b1;
            end else if (|(extQ & cpuIrqEn & wakeDetectEn)) begin
               next_r.state  = ST_QUAL;
               next_r.nmiSrc = 1'b0;
            end
         end
         ST_QUAL: begin
            if (r.width != '1) begin
               next_r.width = r.width + 16'h0001;
            end
            if ((r.nmiSrc && nmiQ) ||
                (!r.nmiSrc && !(|(extQ & cpuIrqEn & wakeDetectEn)))) begin
               // Pulse ended: start oscillator only if it was long enough
               if (r.width >= r.need) begin
                  next_r.state      = ST_WARMUP;
                  next_r.oscStart   = 1'b1;
                  next_r.startPulse = 1'b1;
               end else begin
                  next_r.state = ST_DEEP;
               end
            end
         end
         ST_WARMUP: begin
            if (warmDone && !r.startPulse) begin
               next_r.state    = ST_RUN;
               next_r.sysClkEn = 1'b1;
               next_r.lpState  = 3'b000;
               next_r.cfgReset = 1'b1;
               if (r.fromMode == MODE_DEEP) begin
                  next_r.resetBranch = 1'b1;
                  next_r.cutReinit   = 1'b1;
               end else begin
                  next_r.irqHandle = 1'b1;
               end
            end
         end
         default: begin
            next_r.state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         r          <= '0;
         r.state    <= ST_RUN;
         r.sysClkEn <= 1'b1;
         r.oscStart <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign lowPowerState   = r.lpState;
   assign sysClkEn        = r.sysClkEn;
   assign oscStart        = r.oscStart;
   assign irqHandleStart  = r.irqHandle;
   assign resetBranch     = r.resetBranch;
   assign cutDomainReinit = r.cutReinit;
   assign clkCfgReset     = r.cfgReset;
endmodule
`default_nettype wire

// [core/lpw_warmup_counter.sv]
// Warm-up counter counting oscillator cycles from start
`timescale 1ns/1ps
`default_nettype none
module lpw_warmup_counter
   import lpw_pkg::*;
(
   input  wire logic                clk,      // Oscillator clock
   input  wire logic                rstN,     // Synchronised reset, active low
   input  wire logic                start,    // Pulse: restart counting
   input  wire logic [WARMUP_W-1:0] duration, // Programmed warm-up length
   output logic                     done      // High once duration elapsed
);
   typedef struct packed {
      logic [WARMUP_W-1:0] count;
      logic                running;
      logic                done;
   } lpw_wcnt_type;

   lpw_wcnt_type r;
   lpw_wcnt_type next_r;

   always_comb begin
      next_r = r;
      if (start) begin
         next_r.count   = duration;
         next_r.running = 1'b1;
         next_r.done    = 1'b0;
      end else if (r.running) begin
         if (r.count <= 12'h0001) begin
            next_r.running = 1'b0;
            next_r.done    = 1'b1;
         end else begin
            next_r.count = r.count - 12'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign done = r.done;
endmodule
`default_nettype wire

// [include/lpw_pkg.sv]
// Constants and types for the low power wake and warm-up sequencer
package lpw_pkg;
   localparam int          CLK_HZ        = 25_000_000;
   localparam int          WARMUP_W      = 12;
   localparam int          NUM_EXT       = 10;
   localparam int          NUM_PERIPH    = 8;
   // Wake-pin qualification: at least 500 us after entry settling, else 1500 us
   localparam int          PULSE_SHORT_US = 500;
   localparam int          PULSE_LONG_US  = 1500;
   localparam int          SETTLE_US      = 50;
   localparam int          PULSE_SHORT_CYC = (PULSE_SHORT_US * (CLK_HZ / 1_000_000));
   localparam int          PULSE_LONG_CYC  = (PULSE_LONG_US * (CLK_HZ / 1_000_000));
   localparam int          SETTLE_CYC      = (SETTLE_US * (CLK_HZ / 1_000_000));
   localparam int          CNT_W           = 16;
   // Warm-up duration reference values for software
   localparam logic [11:0] WARMUP_LIGHT  = 12'h0119;
   localparam logic [11:0] WARMUP_DEEP   = 12'h0270;
   // Mode request encoding
   localparam logic [1:0]  MODE_RUN      = 2'h0;
   localparam logic [1:0]  MODE_DOZE     = 2'h1;
   localparam logic [1:0]  MODE_LIGHT    = 2'h2;
   localparam logic [1:0]  MODE_DEEP     = 2'h3;

   typedef enum logic [5:0] {
      ST_RUN    = 6'b000001,
      ST_DOZE   = 6'b000010,
      ST_LIGHT  = 6'b000100,
      ST_DEEP   = 6'b001000,
      ST_QUAL   = 6'b010000,
      ST_WARMUP = 6'b100000
   } lpw_state_type;
endpackage

// [verif/lpw_sequencer_props.sv]
// Port assertions for the wake and warm-up sequencer
`timescale 1ns/1ps
`default_nettype none
module lpw_sequencer_props
   import lpw_pkg::*;
(
   input wire logic                  clk_sys,         // Clock
   input wire logic                  nrst,            // Reset, active low
   input wire logic                  enterReq,        // Entry request
   input wire logic [1:0]            modeSel,         // Requested mode
   input wire logic [NUM_PERIPH-1:0] periphIrq,       // Peripheral requests
   input wire logic                  nmiPinN,         // NMI pin
   input wire logic [2:0]            lowPowerState,   // Mode flags
   input wire logic                  sysClkEn,        // Clock enable
   input wire logic                  oscStart,        // Oscillator on
   input wire logic                  irqHandleStart,  // Handling pulse
   input wire logic                  resetBranch,     // Reset branch pulse
   input wire logic                  cutDomainReinit, // Reinit pulse
   input wire logic                  clkCfgReset      // Select clear pulse
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic inRun;
   assign inRun = (lowPowerState == 3'h0) && sysClkEn;
   sequence enterS(logic [1:0] m);
      inRun && enterReq && (modeSel == m);
   endsequence
   sequence riseS(logic [2:0] st);
      (lowPowerState == st) && $rose(|periphIrq);
   endsequence
   doze_entry_a: assert property (enterS(MODE_DOZE) |=> lowPowerState == 3'h1)
      else $error("doze entry missing");
   light_clk_off_a: assert property (enterS(MODE_LIGHT) |=> lowPowerState == 3'h2 && !sysClkEn)
      else $error("light entry wrong");
   deep_osc_off_a: assert property (enterS(MODE_DEEP) |=> lowPowerState == 3'h4 && !oscStart)
      else $error("deep entry wrong");
   periph_wake_a: assert property (riseS(3'h1) |-> ##[1:3] irqHandleStart)
      else $error("doze peripheral wake missing");
   stop_ignore_a: assert property (riseS(3'h2) |=> (lowPowerState == 3'h2)[*4])
      else $error("stop left on peripheral request");
   handle_run_a: assert property (irqHandleStart |-> lowPowerState == 3'h0 ##1 !irqHandleStart)
      else $error("handling before exit");
   branch_pair_a: assert property (resetBranch |-> cutDomainReinit && clkCfgReset)
      else $error("reset branch pulses split");
   warm_gate_a: assert property ($rose(oscStart) |-> !sysClkEn ##1 !sysClkEn)
      else $error("clock before warm-up");
   deep_hold_a: assert property (lowPowerState == 3'h4 && !nmiPinN |-> !oscStart)
      else $error("oscillator before pin rise");
endmodule
bind lpw_sequencer lpw_sequencer_props u_props (
   .clk_sys, .nrst, .enterReq, .modeSel, .periphIrq, .nmiPinN, .lowPowerState,
   .sysClkEn, .oscStart, .irqHandleStart, .resetBranch, .cutDomainReinit, .clkCfgReset
);
`default_nettype wire

// [verif/lpw_wake_pins.sv]
// Model of the wake pins facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_pins (
   input  wire logic        clk_sys, // Clock
   input  wire logic        fire,    // Start one pulse
   input  wire logic        useNmi,  // 1 NMI pin, 0 external pin
   input  wire logic [15:0] len,     // Active width in cycles
   output logic             nmiPinN, // NMI pin
   output logic             extPin,  // External wake pin
   output logic             busy     // Pulse running
);
   logic [15:0] left = 16'h0000;
   logic        onNmi = 1'b0;
   always_ff @(posedge clk_sys) begin
      if (fire) begin
         left <= len;
         onNmi <= useNmi;
      end else if (busy) begin
         left <= left - 16'h0001;
      end
   end
   assign busy = (left != 16'h0000);
   // Idle levels are the ones deep stop must be entered with
   assign nmiPinN = !(busy && onNmi);
   assign extPin = busy && !onNmi;
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the wake and warm-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import lpw_pkg::*;
;
   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] src;
      logic       det;
      logic       exp;
   } lpw_row_type;
   localparam int DUR = int'(WARMUP_DEEP);
   logic                  clk_sys, nrst, enterReq, tickIrq, watchdog_nmi_request;
   logic                  fire, useNmi, nmiPinN, extPin, sysClkEn, oscStart;
   logic                  irqHandleStart, resetBranch, cutDomainReinit, clkCfgReset;
   logic [1:0]            modeSel;
   logic [2:0]            lowPowerState;
   logic [15:0]           len;
   logic [WARMUP_W-1:0]   warmup_duration;
   logic [NUM_EXT-1:0]    external_wake_irq, wakeDetectEn, cpuIrqEn;
   logic [NUM_PERIPH-1:0] periphIrq;
   int                    nErrors, nChecks, cyc, hits, rb, cr, warm;
   lpw_row_type           r;
   // Sources: 0 peripheral, 1 tick, 2 watchdog, 3 external pin, 4 NMI pin
   lpw_row_type           rows [11] = '{
      '{MODE_DOZE, 3'h0, 1'b0, 1'b1}, '{MODE_DOZE, 3'h1, 1'b0, 1'b1},
      '{MODE_DOZE, 3'h2, 1'b0, 1'b1}, '{MODE_DOZE, 3'h3, 1'b0, 1'b1},
      '{MODE_DOZE, 3'h4, 1'b0, 1'b1}, '{MODE_LIGHT, 3'h0, 1'b1, 1'b0},
      '{MODE_LIGHT, 3'h1, 1'b1, 1'b0}, '{MODE_LIGHT, 3'h2, 1'b1, 1'b0},
      '{MODE_LIGHT, 3'h3, 1'b0, 1'b0}, '{MODE_LIGHT, 3'h3, 1'b1, 1'b1},
      '{MODE_LIGHT, 3'h4, 1'b0, 1'b1}};
   assign external_wake_irq = {{(NUM_EXT-1){1'b0}}, extPin};
   lpw_sequencer u_dut (
      .clk_sys, .nrst, .enterReq, .modeSel, .warmup_duration, .external_wake_irq,
      .wakeDetectEn, .cpuIrqEn, .periphIrq, .tickIrq, .watchdog_nmi_request, .nmiPinN,
      .lowPowerState, .sysClkEn, .oscStart, .irqHandleStart, .resetBranch,
      .cutDomainReinit, .clkCfgReset
   );
   lpw_wake_pins u_pins (.clk_sys, .fire, .useNmi, .len, .nmiPinN, .extPin, .busy());
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (nErrors == 0 && nChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic ticks(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic do_reset();
      nrst = 1'b0;
      ticks(3);
      nrst = 1'b1;
      ticks(3);
      chk(16'({lowPowerState, sysClkEn, oscStart}), 16'h0003);
   endtask
   task automatic enter(input logic [1:0] m);
      modeSel = m;
      enterReq = 1'b1;
      ticks(1);
      enterReq = 1'b0;
   endtask
   task automatic pulse(input logic n, input logic [15:0] w);
      useNmi = n;
      len = w;
      fire = 1'b1;
      ticks(1);
      fire = 1'b0;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Pulses stand one cycle, so the falling edge sees each exactly once
   always @(negedge clk_sys) begin
      cyc++;
      hits += irqHandleStart;
      rb += resetBranch;
      cr += clkCfgReset;
      warm += (oscStart && !sysClkEn);
      if (cyc == 60000) begin
         nErrors++;
         stop_test();
      end
   end
   initial begin
      {nrst, enterReq, tickIrq, watchdog_nmi_request, fire, useNmi} = '0;
      {modeSel, len, periphIrq, wakeDetectEn} = '0;
      cpuIrqEn = '1;
      warmup_duration = WARMUP_LIGHT;
      ticks(1);
      do_reset();
      foreach (rows[i]) begin
         r = rows[i];
         wakeDetectEn = {NUM_EXT{r.det}};
         enter(r.mode);
         ticks(4);
         hits = 0;
         cr = 0;
         case (r.src)
            3'h0: periphIrq = 8'h80;
            3'h1: tickIrq = 1'b1;
            3'h2: watchdog_nmi_request = 1'b1;
            default: pulse(r.src == 3'h4, 16'h0028);
         endcase
         ticks(320);
         chk(16'(hits), {15'h0000, r.exp});
         chk(16'(cr), {15'h0000, r.exp && (r.mode == MODE_LIGHT)});
         chk(16'(lowPowerState), r.exp ? 16'h0000 : {14'h0000, r.mode});
         {periphIrq, tickIrq, watchdog_nmi_request} = '0;
         do_reset();
      end
      wakeDetectEn = '1;
      warmup_duration = WARMUP_DEEP;
      rb = 0;
      cr = 0;
      hits = 0;
      enter(MODE_DEEP);
      ticks(1300);
      pulse(1'b1, 16'h07D0);
      ticks(2100);
      chk(16'(lowPowerState), 16'h0004);
      chk(16'(rb), 16'h0000);
      warm = 0;
      pulse(1'b1, 16'h3138);
      ticks(12550);
      chk(16'(oscStart), 16'h0000);
      ticks(700);
      chk(16'(rb), 16'h0001);
      chk(16'(cr), 16'h0001);
      chk(16'(hits), 16'h0000);
      chk(16'({sysClkEn, lowPowerState}), 16'h0008);
      chk(16'(warm >= DUR), 16'h0001);
      enter(MODE_DEEP);
      ticks(1300);
      pulse(1'b0, 16'h3138);
      ticks(13300);
      chk(16'(rb), 16'h0002);
      chk(16'(sysClkEn), 16'h0001);
      // Early pulse: inside the settling window the long minimum applies
      enter(MODE_DEEP);
      ticks(10);
      pulse(1'b1, 16'h3138);
      ticks(12650);
      chk(16'(lowPowerState), 16'h0004);
      chk(16'(oscStart), 16'h0000);
      chk(16'(rb), 16'h0002);
      stop_test();
   end
endmodule
`default_nettype wire
